// >>> bench/icct_pins_model.sv
// Pin-side model: capture pins and a free-running filter tick source.
`default_nettype none
module icct_pins_model (
    input  wire logic       clock,
    output var  logic [5:0] capture_input,
    output var  logic       filter_tick_clock
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_reg = 2'h0;
    initial capture_input = 6'h00;
    always @(posedge clock) begin
        div_reg <= div_reg + 2'h1;
    end
    // Ticks come at a quarter rate, so a short pulse spans few ticks.
    assign filter_tick_clock = div_reg[1];
    task automatic drive(input int ch, input logic lvl);
        @(posedge clock);
        capture_input[ch] <= lvl;
    endtask
endmodule
`default_nettype wire

// >>> bench/icct_timer_props.sv
// Checker of the capture and compare timer port behaviour.
`default_nettype none
module icct_timer_props (
    input wire logic                    clock,
    input wire logic                    srst,
    input wire logic [5:0]              capture_input,
    input wire logic                    filter_tick_clock,
    input wire icct_pkg::icct_cap_cfg_t cap_cfg [6],
    input wire logic [1:0]              compare_enable,
    input wire logic [31:0]             compare_value [2],
    input wire logic [31:0]             count_value,
    input wire logic [31:0]             capture_value [6],
    input wire icct_pkg::icct_events_t  events,
    input wire logic                    compare_output_first,
    input wire logic                    compare_output_second
);
    // ==========================================================
    // Helper logic
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    logic [1:0] hit_reg;
    always_ff @(posedge clock) begin
        hit_reg <= compare_enable & {count_value == compare_value[1],
                                     count_value == compare_value[0]};
    end
    // ==========================================================
    // Assertions
    a_count_step: assert property (!$past(srst) |->
        count_value == $past(count_value) + 32'h1) else $error("count step");
    a_wrap_exact: assert property (events.wrap ==
        (count_value == 32'h0 && $past(count_value) == 32'hFFFF_FFFF))
        else $error("wrap event");
    a_cmp_event: assert property (!$past(srst) |->
        events.compare == hit_reg) else $error("compare event");
    a_toggle_one: assert property (!$past(srst) |->
        $changed(compare_output_first) == events.compare[0])
        else $error("first toggle");
    a_toggle_two: assert property (!$past(srst) |->
        $changed(compare_output_second) == events.compare[1])
        else $error("second toggle");
    for (genvar i = 0; i < 6; i++) begin : g_cap
        a_cap_value: assert property (!$past(srst) &&
            $changed(capture_value[i]) |-> capture_value[i] ==
            $past(count_value)) else $error("capture value");
        a_cap_event: assert property (!$past(srst) |->
            events.capture[i] == $changed(capture_value[i]))
            else $error("capture event");
        a_cap_off: assert property (!$past(srst) &&
            $past(cap_cfg[i].edge_sel) == icct_pkg::ICCT_EDGE_OFF |->
            $stable(capture_value[i])) else $error("disabled capture");
    end
endmodule
bind icct_timer icct_timer_props i_props (.clock(clock), .srst(srst),
    .capture_input(capture_input), .filter_tick_clock(filter_tick_clock),
    .cap_cfg(cap_cfg), .compare_enable(compare_enable),
    .compare_value(compare_value), .count_value(count_value),
    .capture_value(capture_value), .events(events),
    .compare_output_first(compare_output_first),
    .compare_output_second(compare_output_second));
`default_nettype wire

// >>> bench/icct_timer_tb.sv
// Self-checking bench of the capture and compare timer.
`default_nettype none
module icct_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [5:0] pins;
    logic tick;
    icct_pkg::icct_cap_cfg_t cfg [6];
    logic [1:0] cmp_en = 2'h0;
    logic [31:0] cmp_val [2];
    logic [31:0] count;
    logic [31:0] cap [6];
    icct_pkg::icct_events_t ev;
    logic [8:0] evb;
    logic [1:0] tog;
    int errors = 0;
    int n_compared = 0;
    assign evb = ev;
    always #20 clock = ~clock;
    icct_pins_model i_pins (.clock(clock), .capture_input(pins),
        .filter_tick_clock(tick));
    icct_timer i_dut (.clock(clock), .srst(srst), .capture_input(pins),
        .filter_tick_clock(tick), .cap_cfg(cfg), .compare_enable(cmp_en),
        .compare_value(cmp_val), .count_value(count), .capture_value(cap),
        .events(ev), .compare_output_first(tog[0]),
        .compare_output_second(tog[1]));
    task automatic final_report();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // A missed wanted event ends the run, as nothing after it is reliable.
    task automatic wait_ev(input int b, n, input logic want, output logic hit);
        hit = 1'b0;
        for (int i = 0; i < n && !hit; i++) begin
            @(posedge clock);
            #1;
            hit = (evb[b] === 1'b1);
        end
        chk("event", 32'(want), 32'(hit));
        if (want && !hit) final_report();
    endtask
    task automatic t_reset();
        logic [31:0] c;
        c = count;
        @(posedge clock);
        #1;
        chk("count", c + 32'h1, count);
        for (int i = 0; i < 6; i++) chk("cap", 32'h0, cap[i]);
        chk("toggles", 32'h0, 32'(tog));
        chk("wrap", 32'h0, 32'(ev.wrap));
    endtask
    task automatic t_capture(input int ch, m);
        logic hit;
        @(posedge clock);
        cfg[ch] <= '{icct_pkg::icct_edge_t'(m), ch[0]};
        for (int l = 1; l >= 0; l--) begin
            i_pins.drive(ch, l[0]);
            wait_ev(3 + ch, 40, m == 2 || m == 1 - l, hit);
            if (hit) chk("capture", count - 32'h1, cap[ch]);
        end
    endtask
    task automatic t_glitch();
        logic hit;
        @(posedge clock);
        cfg[0] <= '{icct_pkg::ICCT_EDGE_BOTH, 1'b0};
        i_pins.drive(0, 1'b1);
        repeat (6) @(posedge clock);
        i_pins.drive(0, 1'b0);
        wait_ev(3, 40, 1'b0, hit);
    endtask
    task automatic t_compare(input int k);
        logic hit;
        @(posedge clock);
        cmp_val[k] <= count + 32'h10;
        wait_ev(1 + k, 30, 1'b0, hit);
        chk("idle toggle", 32'h0, 32'(tog[k]));
        for (int r = 1; r >= 0; r--) begin
            @(posedge clock);
            cmp_en[k] <= 1'b1;
            cmp_val[k] <= count + 32'h10;
            wait_ev(1 + k, 30, 1'b1, hit);
            chk("match count", cmp_val[k] + 32'h1, count);
            chk("toggle", 32'(r[0]), 32'(tog[k]));
        end
    endtask
    initial begin
        for (int i = 0; i < 6; i++) cfg[i] = '{icct_pkg::ICCT_EDGE_OFF, 1'b0};
        cmp_val[0] = 32'h0;
        cmp_val[1] = 32'h0;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        t_reset();
        for (int c = 0; c < 6; c++)
            for (int m = 0; m < 4; m++) t_capture(c, m);
        t_glitch();
        t_compare(0);
        t_compare(1);
        @(posedge clock);
        srst <= 1'b1;
        @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        #1;
        t_reset();
        final_report();
    end
endmodule
`default_nettype wire

// >>> inc/icct_pkg.sv
// Package of constants and types for the capture and compare timer.
`default_nettype none
package icct_pkg;
    // ==========================================================
    // Sizes, reset values and the all-ones count value
    localparam int unsigned    CAP_CHANNELS = 6;
    localparam int unsigned    CMP_CHANNELS = 2;
    localparam int unsigned    COUNT_WIDTH  = 32;
    localparam int unsigned    FILTER_TICKS = 3;
    localparam logic [31:0]    COUNT_RESET  = 32'h0000_0000;
    localparam logic [31:0]    COUNT_ALL_ONES = 32'hFFFF_FFFF;
    localparam logic [1:0]     SYNC_RESET   = 2'h0;

    // ==========================================================
    // Edge selection per capture channel
    typedef enum logic [1:0] {
        ICCT_EDGE_RISING  = 2'b00,
        ICCT_EDGE_FALLING = 2'b01,
        ICCT_EDGE_BOTH    = 2'b10,
        ICCT_EDGE_OFF     = 2'b11
    } icct_edge_t;

    // Configuration of one capture channel.
    typedef struct packed {
        icct_edge_t edge_sel;
        logic       filter_bypass;
    } icct_cap_cfg_t;

    // Event pulses of the block.
    typedef struct packed {
        logic [5:0] capture;
        logic [1:0] compare;
        logic       wrap;
    } icct_events_t;
endpackage
`default_nettype wire

// >>> rtl/icct_timer.sv
// Capture and compare timer with a shared free-running counter.
// What this block does
// - One free-running 32-bit counter advances every clock as shared time base.
// - Six 32-bit capture registers and two compare values share that counter.
// - A capture register latches the counter on its programmed input edge.
// - Each capture register pulses its own event when it takes a value.
// - A wrap event pulses when the counter starts again from zero.
// - Each compare channel pulses an event when counter equals its value.
// - The wrap event fires exactly on the all-ones to zero step.
// - Each compare output is a toggle flop inverted on every match.
// - Capture values are read only and every edge overwrites them.
// - Unbypassed filter needs three steady filter ticks before level changes.
`default_nettype none
module icct_timer #(
    parameter int unsigned CAP_CHANNELS = icct_pkg::CAP_CHANNELS,
    parameter int unsigned CMP_CHANNELS = icct_pkg::CMP_CHANNELS,
    parameter int unsigned COUNT_WIDTH  = icct_pkg::COUNT_WIDTH,
    parameter int unsigned FILTER_TICKS = icct_pkg::FILTER_TICKS
) (
    input  wire logic                     clock,
    input  wire logic                     srst,
    input  wire logic [5:0]               capture_input,
    input  wire logic                     filter_tick_clock,
    input  wire icct_pkg::icct_cap_cfg_t  cap_cfg [6],
    input  wire logic [1:0]               compare_enable,
    input  wire logic [31:0]              compare_value [2],
    output var  logic [31:0]              count_value,
    output var  logic [31:0]              capture_value [6],
    output var  icct_pkg::icct_events_t   events,
    output var  logic                     compare_output_first,
    output var  logic                     compare_output_second
);
    // ==========================================================
    // Parameter checks
    // The port list is sized for six captures, two compares and a
    // 32-bit count, so any other size is refused here.
    generate
        if (CAP_CHANNELS != 6) begin : g_bad_cap
            $error("icct_timer: CAP_CHANNELS must be 6");
        end

        if (CMP_CHANNELS != 2) begin : g_bad_cmp
            $error("icct_timer: CMP_CHANNELS must be 2");
        end

        if (COUNT_WIDTH != 32) begin : g_bad_width
            $error("icct_timer: COUNT_WIDTH must be 32");
        end

        // The filter run counter is two bits wide.
        if (FILTER_TICKS < 1 || FILTER_TICKS > 4) begin : g_bad_ticks
            $error("icct_timer: FILTER_TICKS must be 1 to 4");
        end
    endgenerate

    // ==========================================================
    // Local sizes
    localparam logic [1:0] RUN_LAST = 2'(FILTER_TICKS - 1);

    // ==========================================================
    // Free-running counter
    // The counter never stops or saturates; it simply rolls over.
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic        wrap_now;
    assign count_next = count_reg + 32'h0000_0001;
    assign wrap_now   = (count_reg == icct_pkg::COUNT_ALL_ONES);

    always_ff @(posedge clock) begin
        if (srst) begin
            count_reg <= icct_pkg::COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end
    assign count_value = count_reg;

    // ==========================================================
    // Filter tick: the tick pin is asynchronous, so it is synchronised.
    // The first flop may go metastable, so only the second is read.
    logic [1:0] tick_sync_reg;
    logic       tick_prev_reg;
    logic       tick_pulse;
    always_ff @(posedge clock) begin
        if (srst) begin
            tick_sync_reg <= icct_pkg::SYNC_RESET;
            tick_prev_reg <= 1'b0;
        end else begin
            tick_sync_reg <= {tick_sync_reg[0], filter_tick_clock};
            tick_prev_reg <= tick_sync_reg[1];
        end
    end
    assign tick_pulse = tick_sync_reg[1] & ~tick_prev_reg;

    // ==========================================================
    // Edge decode, shared by every channel.
    function automatic logic edge_hit(input icct_pkg::icct_edge_t sel,
                                      input logic rise,
                                      input logic fall);
        case (sel)
            icct_pkg::ICCT_EDGE_RISING:  edge_hit = rise;
            icct_pkg::ICCT_EDGE_FALLING: edge_hit = fall;
            icct_pkg::ICCT_EDGE_BOTH:    edge_hit = rise | fall;
            icct_pkg::ICCT_EDGE_OFF:     edge_hit = 1'b0;
            default:                     edge_hit = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // Capture channels
    // Each channel: two-flop synchroniser, optional filter, edge detect.
    logic [5:0] cap_hit;
    genvar g;
    generate
        for (g = 0; g < CAP_CHANNELS; g++) begin : g_cap
            logic [1:0]  sync_reg;
            logic [1:0]  stable_reg;
            logic        filt_reg;
            logic        level_prev_reg;
            logic [31:0] value_reg;
            logic        level;
            logic        rise;
            logic        fall;
            logic        differs;
            logic        filt_step;
            logic        filt_done;

            assign differs = (sync_reg[1] != filt_reg);
            assign level   = cap_cfg[g].filter_bypass ? sync_reg[1]
                                                      : filt_reg;
            assign rise    = level & ~level_prev_reg;
            assign fall    = ~level & level_prev_reg;
            // Switching the bypass while the pin moves may show one edge.
            // A tick while the levels differ advances the run.
            assign filt_step = differs & tick_pulse;
            assign filt_done = filt_step & (stable_reg == RUN_LAST);
            assign cap_hit[g] = edge_hit(cap_cfg[g].edge_sel, rise, fall);

            always_ff @(posedge clock) begin
                if (srst) begin
                    sync_reg   <= icct_pkg::SYNC_RESET;
                    stable_reg <= 2'h0;
                    filt_reg   <= 1'b0;
                end else begin
                    sync_reg <= {sync_reg[0], capture_input[g]};
                    if (!differs) begin
                        stable_reg <= 2'h0;
                    end else if (filt_done) begin
                        filt_reg   <= sync_reg[1];
                        stable_reg <= 2'h0;
                    end else if (filt_step) begin
                        stable_reg <= stable_reg + 2'h1;
                    end
                end
            end

            always_ff @(posedge clock) begin
                if (srst) begin
                    level_prev_reg <= 1'b0;
                    value_reg      <= icct_pkg::COUNT_RESET;
                end else begin
                    level_prev_reg <= level;
                    if (cap_hit[g]) begin
                        // A later edge overwrites an unread value.
                        value_reg <= count_reg;
                    end
                end
            end
            assign capture_value[g] = value_reg;
        end
    endgenerate

    // ==========================================================
    // Compare channels
    // Matching is exact equality, so a value the counter has already
    // passed waits for the next lap of the counter.
    logic [1:0] cmp_equal;
    logic [1:0] cmp_hit;
    logic [1:0] toggle_reg;
    generate
        for (g = 0; g < CMP_CHANNELS; g++) begin : g_cmp
            assign cmp_equal[g] = (count_reg == compare_value[g]);
            assign cmp_hit[g]   = compare_enable[g] & cmp_equal[g];
            always_ff @(posedge clock) begin
                if (srst) begin
                    toggle_reg[g] <= 1'b0;
                end else if (cmp_hit[g]) begin
                    toggle_reg[g] <= ~toggle_reg[g];
                end
            end
        end
    endgenerate
    assign compare_output_first  = toggle_reg[0];
    assign compare_output_second = toggle_reg[1];

    // ==========================================================
    // Event pulses, registered so outputs come from flops.
    // This costs one cycle of latency but keeps glitches off the events.
    // Each pulse stands for exactly one cycle.
    icct_pkg::icct_events_t events_reg;
    always_ff @(posedge clock) begin
        if (srst) begin
            events_reg <= '0;
        end else begin
            events_reg.capture <= cap_hit;
            events_reg.compare <= cmp_hit;
            events_reg.wrap    <= wrap_now;
        end
    end
    assign events = events_reg;
endmodule
`default_nettype wire
